// ### testbench/pafm_pins_model.sv
// Board pins and peripheral outputs facing one port of the pin mux
`timescale 1ns/1ps
module pafm_pins_model #(
  parameter int W = 16
) (
  input wire logic [W-1:0] pin_out,
  input wire logic [W-1:0] pin_oe,
  input wire logic [W-1:0] ext_level,
  input wire logic [W-1:0] oe_req,
  output logic [W-1:0] pin_in,
  output logic [W-1:0] f1,
  output logic [W-1:0] f2,
  output logic [W-1:0] f3,
  output logic [W-1:0] alt_oe
);
  // Driven bits read back the mux; released bits see the board level
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
  // Distinct peripheral patterns, so a wrong select shows except at bits 1 and 5 of each byte, where all three agree; none of
  // them detects edges or key returns, so a shared pin has one listener
  assign f1 = {(W/8){8'hC3}};
  assign f2 = {(W/8){8'h5A}};
  assign f3 = {(W/8){8'h96}};
  assign alt_oe = oe_req;
endmodule // pafm_pins_model

// ### testbench/port_alt_function_mux_test.sv
// Self-checking bench for the port pin mux and its register file
`timescale 1ns/1ps
module port_alt_function_mux_test;
  import pafm_pkg::*;
  typedef struct packed {
    logic [7:0] wadr;
    logic [3:0] sel;
    logic [31:0] wdat;
    logic [7:0] radr;
    logic [31:0] rexp;
  } pafm_row_s;
  logic clock, sys_rst, wb_ack_o;
  pafm_wb_req_s wb_req;
  logic [31:0] wb_dat_o, rd;
  logic [15:0] p9_pin_in, p9_pin_out, p9_pin_oe, p9_pullup_en, p9_alt_in;
  logic [15:0] p9_f1, p9_f2, p9_f3, p9_aoe, p9_ext, p9_oreq;
  logic [7:0] p5_pin_in, p5_pin_out, p5_pin_oe, p5_alt_in;
  logic [7:0] p5_f1, p5_f2, p5_f3, p5_aoe, p5_ext, p5_oreq;
  logic [15:0] p7_pin_in, p7_pin_out, p7_pin_oe, analog_input_n, p7_ext;
  logic port0_pin5_in, debug_reset_input, port0_pin5_gpio_in;
  logic debug_pins_sel, flash_prog_mode_pin1_in, flash_prog_mode;
  int n_fail;
  int compares;
  pafm_row_s rows [8];

  port_alt_function_mux i_port_alt_function_mux (
    .clock(clock), .sys_rst(sys_rst), .wb_req(wb_req),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .p9_pin_in(p9_pin_in), .p9_pin_out(p9_pin_out),
    .p9_pin_oe(p9_pin_oe), .p9_pullup_en(p9_pullup_en),
    .p9_alt_f1(p9_f1), .p9_alt_f2(p9_f2), .p9_alt_f3(p9_f3),
    .p9_alt_oe(p9_aoe), .p9_alt_in(p9_alt_in),
    .p5_pin_in(p5_pin_in), .p5_pin_out(p5_pin_out),
    .p5_pin_oe(p5_pin_oe), .p5_alt_f1(p5_f1), .p5_alt_f2(p5_f2),
    .p5_alt_f3(p5_f3), .p5_alt_oe(p5_aoe), .p5_alt_in(p5_alt_in),
    .p7_pin_in(p7_pin_in), .p7_pin_out(p7_pin_out),
    .p7_pin_oe(p7_pin_oe), .analog_input_n(analog_input_n),
    .port0_pin5_in(port0_pin5_in), .debug_reset_input(debug_reset_input),
    .port0_pin5_gpio_in(port0_pin5_gpio_in),
    .debug_pins_sel(debug_pins_sel),
    .flash_prog_mode_pin1_in(flash_prog_mode_pin1_in),
    .flash_prog_mode(flash_prog_mode)
  );
  // Far side of each port; port 7 has no digital peripheral to model
  pafm_pins_model #(.W(16)) i_pafm_pins_model_p9 (
    .pin_out(p9_pin_out), .pin_oe(p9_pin_oe), .ext_level(p9_ext),
    .oe_req(p9_oreq), .pin_in(p9_pin_in), .f1(p9_f1), .f2(p9_f2),
    .f3(p9_f3), .alt_oe(p9_aoe)
  );
  pafm_pins_model #(.W(8)) i_pafm_pins_model_p5 (
    .pin_out(p5_pin_out), .pin_oe(p5_pin_oe), .ext_level(p5_ext),
    .oe_req(p5_oreq), .pin_in(p5_pin_in), .f1(p5_f1), .f2(p5_f2),
    .f3(p5_f3), .alt_oe(p5_aoe)
  );
  pafm_pins_model #(.W(16)) i_pafm_pins_model_p7 (
    .pin_out(p7_pin_out), .pin_oe(p7_pin_oe), .ext_level(p7_ext),
    .oe_req(16'h0000), .pin_in(p7_pin_in), .f1(), .f2(), .f3(),
    .alt_oe()
  );

  // Free-running system clock
  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task automatic report_and_stop;
    $display("Compares %0d, n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    compares++;
    if (got !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Classic single cycle; holds everything until ack is seen high
  task automatic wb(input logic we, input logic [7:0] a,
                    input logic [3:0] s, input logic [31:0] d);
    wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: s, adr: a, dat: d};
    // Only the watchdog ends a wait that never sees ack
    do
    begin
      @(posedge clock);
    end
    while (wb_ack_o !== 1'b1);
    chk("bus ack", 32'h1, {31'h0, wb_ack_o});
    rd = wb_dat_o;
    wb_req <= '0;
    @(posedge clock);
  endtask

  // Expected pin output: latch in port mode, selected peripheral else
  function automatic logic [15:0] mux_out(input logic [15:0] m, lat, fs,
                                          fx, a, b, c);
    return (~m & lat) | (m & fs & ~fx & a) | (m & ~fs & fx & b) |
           (m & fs & fx & c);
  endfunction

  // Watchdog: the whole sequence needs well under a thousand cycles
  initial
  begin
    repeat (5000) @(posedge clock);
    n_fail++;
    $display("CHECK FAILED watchdog expected done seen hang");
    report_and_stop;
  end

  // Main sequence
  initial
  begin
    n_fail = 0;
    compares = 0;
    sys_rst = 1'b1;
    wb_req = '0;
    p9_ext = 16'hA5A5;
    p9_oreq = 16'h00FF;
    p5_ext = 8'h3C;
    p5_oreq = 8'hF0;
    p7_ext = 16'h1111;
    port0_pin5_in = 1'b0;
    flash_prog_mode_pin1_in = 1'b0;
    rows = '{
      '{PAFM_P9_FSEL, 4'h3, 32'hFFFF, PAFM_P9_FSEL_H, 32'hFF},
      '{PAFM_P9_FEXT_H, 4'h1, 32'hCD, PAFM_P9_FEXT, 32'hCD00},
      '{PAFM_P9_MODE, 4'h3, 32'h1234, PAFM_P9_MODE, 32'h1234},
      '{PAFM_P9_MODE_H, 4'h1, 32'hAB, PAFM_P9_MODE, 32'hAB34},
      '{PAFM_P9_PULL, 4'h1, 32'hEF, PAFM_P9_PULL, 32'hEF},
      '{PAFM_P9_PULL_H, 4'h1, 32'h77, PAFM_P9_PULL_H, 32'h77},
      '{PAFM_P9_DIR, 4'h2, 32'hAA55, PAFM_P9_DIR, 32'hAAFF},
      '{8'hFC, 4'h3, 32'h1234, 8'hFC, 32'h0}};
    repeat (3) @(posedge clock);
    sys_rst <= 1'b0;
    port0_pin5_in <= 1'b1;
    @(posedge clock);
    @(posedge clock);
    chk("debug pins", 32'h1, {31'h0, debug_pins_sel});
    chk("debug reset", 32'h1, {31'h0, debug_reset_input});
    wb(1'b0, PAFM_DBG_CTRL, 4'hF, 32'h0);
    chk("debug ctrl", 32'h3, rd);
    foreach (rows[i])
    begin
      wb(1'b1, rows[i].wadr, rows[i].sel, rows[i].wdat);
      wb(1'b0, rows[i].radr, 4'h3, 32'h0);
      chk("row read", rows[i].rexp, rd);
    end
    chk("pull-up", 32'h77EF, p9_pullup_en);
    // Data read mixes latch and pin by direction
    wb(1'b1, PAFM_P9_MODE, 4'h3, 32'h0);
    wb(1'b1, PAFM_P9_DIR, 4'h3, 32'h00FF);
    wb(1'b1, PAFM_P9_DATA, 4'h3, 32'h1234);
    wb(1'b0, PAFM_P9_DATA, 4'h3, 32'h0);
    chk("p9 data", 32'h12A5, rd);
    // Selects first, mode last; bit 1 takes the key-return setting
    wb(1'b1, PAFM_P9_FSEL, 4'h3, 32'h00AA);
    wb(1'b1, PAFM_P9_FEXT, 4'h3, 32'h00CC);
    chk("p9 alt in off", 32'h0, p9_alt_in);
    // Only pins with a nonzero select enter control mode
    wb(1'b1, PAFM_P9_MODE, 4'h3, 32'h00EE);
    chk("p9 out", mux_out(16'h00EE, 16'h1234, 16'h00AA, 16'h00CC,
        p9_f1, p9_f2, p9_f3), p9_pin_out);
    chk("p9 oe", 16'hFF00 | (16'h00EE & p9_oreq), p9_pin_oe);
    chk("p9 alt in", 16'h00EE & p9_pin_in, p9_alt_in);
    // Port 5 follows the same select ordering
    wb(1'b1, PAFM_P5_DATA, 4'h1, 32'h0F);
    wb(1'b1, PAFM_P5_DIR, 4'h1, 32'h00);
    wb(1'b1, PAFM_P5_FSEL, 4'h1, 32'hAA);
    wb(1'b1, PAFM_P5_FEXT, 4'h1, 32'hCC);
    wb(1'b1, PAFM_P5_MODE, 4'h1, 32'hE0);
    chk("p5 out", mux_out(16'h00E0, 16'h000F, 16'h00AA, 16'h00CC,
        {8'h0, p5_f1}, {8'h0, p5_f2}, {8'h0, p5_f3}),
        {16'h0, 8'h0, p5_pin_out});
    chk("p5 oe", {24'h0, 8'h1F | (8'hE0 & p5_oreq)},
        {24'h0, p5_pin_oe});
    chk("p5 alt in", {24'h0, 8'hE0 & p5_pin_in},
        {24'h0, p5_alt_in});
    // Port 7: input direction routes the analog path
    wb(1'b1, PAFM_P7_DIR, 4'h3, 32'h0F0F);
    chk("analog sel", 32'h0F0F, analog_input_n);
    wb(1'b1, PAFM_P7_DATA, 4'h3, 32'h2222);
    wb(1'b0, PAFM_P7_DATA, 4'h3, 32'h0);
    chk("p7 data", 32'h2121, rd);
    // Release the debug pins to general use
    wb(1'b1, PAFM_DBG_CTRL, 4'h1, 32'h0);
    chk("debug pins off", 32'h0, {31'h0, debug_pins_sel});
    chk("debug reset off", 32'h0, {31'h0, debug_reset_input});
    chk("pin5 gpio", 32'h1, {31'h0, port0_pin5_gpio_in});
    flash_prog_mode_pin1_in <= 1'b1;
    @(posedge clock);
    chk("flash mode", 32'h1, {31'h0, flash_prog_mode});
    // Second reset in mid-run restores the debug ownership
    sys_rst <= 1'b1;
    repeat (3) @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
    @(posedge clock);
    chk("debug pins rst", 32'h1, {31'h0, debug_pins_sel});
    chk("flash after rst", 32'h1, {31'h0, flash_prog_mode});
    chk("p9 oe rst", 32'h0, p9_pin_oe);
    wb(1'b0, PAFM_P9_MODE, 4'h3, 32'h0);
    chk("mode rst", 32'h0, rd);
    report_and_stop;
  end
endmodule // port_alt_function_mux_test

// ### verilog/pafm_pkg.sv
// Package with register map, field layout and shared types of the pin mux
// Functional notes
// (RULE_01) Port 9 control mode with both selects zero gives undefined output.
// (RULE_02) Software programs port 9 select bits before setting mode-control.
// (RULE_03) Port 9 16-bit registers expose bits 8-15 via high-byte alias.
// (RULE_04) Serial1 receive use needs key-return mask bit 7 cleared.
// (RULE_05) Key-return 7 use: func select bit1 one, extended bit1 zero.
// (RULE_06) External reset makes port 0 pin 5 the debug reset input.
// (RULE_07) Serial0 receive use needs ext irq 7 edge selects cleared.
// (RULE_08) Ext irq 7 use needs serial0 receive enable cleared.
// (RULE_09) Timer capture on shared pins 0-3 needs key-return mask cleared.
// (RULE_10) Key-return on shared pins 0-3 needs timer capture edges disabled.
// (RULE_11) After external reset the four debug pins belong to debug.
// (RULE_12) Port 5 same ordering; select bits before mode-control bit.
// (RULE_13) Port 7 analog input needs direction bit one (input).
// (RULE_14) Flash programming mode pin ignores all port control registers.
// (RULE_15) Data read gives latch when direction zero, pin when one.
// (RULE_16) Alternate-function input is mode-control bit AND pin level.
// (RULE_17) High-byte alias write changes only bits 8-15 of shared storage.
package pafm_pkg;
  localparam int PAFM_AW = 8;
  localparam int PAFM_PW = 16;
  // Word offsets (byte addresses), one register per aligned word
  localparam logic [7:0] PAFM_P9_DATA = 8'h00;
  localparam logic [7:0] PAFM_P9_DATA_H = 8'h04;
  localparam logic [7:0] PAFM_P9_DIR = 8'h08;
  localparam logic [7:0] PAFM_P9_DIR_H = 8'h0C;
  localparam logic [7:0] PAFM_P9_MODE = 8'h10;
  localparam logic [7:0] PAFM_P9_MODE_H = 8'h14;
  localparam logic [7:0] PAFM_P9_FSEL = 8'h18;
  localparam logic [7:0] PAFM_P9_FSEL_H = 8'h1C;
  localparam logic [7:0] PAFM_P9_FEXT = 8'h20;
  localparam logic [7:0] PAFM_P9_FEXT_H = 8'h24;
  localparam logic [7:0] PAFM_P9_PULL = 8'h28;
  localparam logic [7:0] PAFM_P9_PULL_H = 8'h2C;
  localparam logic [7:0] PAFM_P5_DATA = 8'h30;
  localparam logic [7:0] PAFM_P5_DIR = 8'h34;
  localparam logic [7:0] PAFM_P5_MODE = 8'h38;
  localparam logic [7:0] PAFM_P5_FSEL = 8'h3C;
  localparam logic [7:0] PAFM_P5_FEXT = 8'h40;
  localparam logic [7:0] PAFM_P7_DATA = 8'h44;
  localparam logic [7:0] PAFM_P7_DIR = 8'h48;
  localparam logic [7:0] PAFM_DBG_CTRL = 8'h4C;
  // Reset values and byte-lane masks
  localparam logic [15:0] PAFM_RST_ZERO = 16'h0000;
  localparam logic [15:0] PAFM_RST_DIR = 16'hFFFF;
  localparam logic [1:0] PAFM_RST_DBG = 2'h3;
  localparam logic [15:0] PAFM_LOW_MASK = 16'h00FF;
  localparam logic [15:0] PAFM_HIGH_MASK = 16'hFF00;
  // Debug control bits
  localparam int PAFM_DBG_RST_BIT = 0;
  localparam int PAFM_DBG_PINS_BIT = 1;
  // Per-pin alternate function choice from {ext, fsel}
  typedef enum logic [1:0] {
    PAFM_ALT_NONE,
    PAFM_ALT_F1,
    PAFM_ALT_F2,
    PAFM_ALT_F3
  } pafm_alt_e;
  // Wishbone request as one bundle
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [PAFM_AW-1:0] adr;
    logic [31:0] dat;
  } pafm_wb_req_s;
endpackage

// ### verilog/pafm_port.sv
// One generic port: data latch, direction and mux per pin
`timescale 1ns/1ps
module pafm_port #(
  parameter int WIDTH = 16
) (
  input wire logic [WIDTH-1:0] latch,
  input wire logic [WIDTH-1:0] dir,
  input wire logic [WIDTH-1:0] mode,
  input wire logic [WIDTH-1:0] fsel,
  input wire logic [WIDTH-1:0] fext,
  input wire logic [WIDTH-1:0] pin_in,
  input wire logic [WIDTH-1:0] alt_f1_out,
  input wire logic [WIDTH-1:0] alt_f2_out,
  input wire logic [WIDTH-1:0] alt_f3_out,
  input wire logic [WIDTH-1:0] alt_oe,
  output logic [WIDTH-1:0] pin_out,
  output logic [WIDTH-1:0] pin_oe,
  output logic [WIDTH-1:0] alt_in,
  output logic [WIDTH-1:0] read_val
);
  import pafm_pkg::*;
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++)
    begin : g_pin
      pafm_alt_e sel;
      assign sel = pafm_alt_e'({fext[i], fsel[i]});
      // Both selects zero in control mode: output undefined, drive low
      always_comb
      begin
        unique case (sel)
          PAFM_ALT_NONE: pin_out[i] = 1'b0; // RULE_01 RULE_12
          PAFM_ALT_F1: pin_out[i] = alt_f1_out[i];
          PAFM_ALT_F2: pin_out[i] = alt_f2_out[i];
          PAFM_ALT_F3: pin_out[i] = alt_f3_out[i];
        endcase
        if (!mode[i])
          pin_out[i] = latch[i];
      end
      // Direction one means input
      assign pin_oe[i] = mode[i] ? alt_oe[i] : ~dir[i];
      // Gated input keeps idle peripherals from seeing pin activity
      assign alt_in[i] = mode[i] & pin_in[i]; // RULE_16
      assign read_val[i] = dir[i] ? pin_in[i] : latch[i]; // RULE_15
    end
  endgenerate
endmodule // pafm_port

// ### verilog/port_alt_function_mux.sv
// Top level pin mux with Wishbone register file for ports 5, 7 and 9
`timescale 1ns/1ps
module port_alt_function_mux #(
  parameter int P9W = 16,
  parameter int P5W = 8,
  parameter int P7W = 16
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire pafm_pkg::pafm_wb_req_s wb_req,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [P9W-1:0] p9_pin_in,
  output logic [P9W-1:0] p9_pin_out,
  output logic [P9W-1:0] p9_pin_oe,
  output logic [P9W-1:0] p9_pullup_en,
  input wire logic [P9W-1:0] p9_alt_f1,
  input wire logic [P9W-1:0] p9_alt_f2,
  input wire logic [P9W-1:0] p9_alt_f3,
  input wire logic [P9W-1:0] p9_alt_oe,
  output logic [P9W-1:0] p9_alt_in,
  input wire logic [P5W-1:0] p5_pin_in,
  output logic [P5W-1:0] p5_pin_out,
  output logic [P5W-1:0] p5_pin_oe,
  input wire logic [P5W-1:0] p5_alt_f1,
  input wire logic [P5W-1:0] p5_alt_f2,
  input wire logic [P5W-1:0] p5_alt_f3,
  input wire logic [P5W-1:0] p5_alt_oe,
  output logic [P5W-1:0] p5_alt_in,
  input wire logic [P7W-1:0] p7_pin_in,
  output logic [P7W-1:0] p7_pin_out,
  output logic [P7W-1:0] p7_pin_oe,
  output logic [P7W-1:0] analog_input_n,
  input wire logic port0_pin5_in,
  output logic debug_reset_input,
  output logic port0_pin5_gpio_in,
  output logic debug_pins_sel,
  input wire logic flash_prog_mode_pin1_in,
  output logic flash_prog_mode
);
  import pafm_pkg::*;

  logic [15:0] p9_data_reg, p9_data_next, p9_dir_reg, p9_dir_next;
  logic [15:0] p9_mode_reg, p9_mode_next, p9_fsel_reg, p9_fsel_next;
  logic [15:0] p9_fext_reg, p9_fext_next, p9_pull_reg, p9_pull_next;
  logic [15:0] p5_data_reg, p5_data_next, p5_dir_reg, p5_dir_next;
  logic [15:0] p5_mode_reg, p5_mode_next, p5_fsel_reg, p5_fsel_next;
  logic [15:0] p5_fext_reg, p5_fext_next;
  logic [15:0] p7_data_reg, p7_data_next, p7_dir_reg, p7_dir_next;
  logic [1:0] dbg_reg, dbg_next;
  logic ack_reg, ack_next;
  logic [31:0] rdat_reg, rdat_next;
  logic [P9W-1:0] p9_rd;
  logic [P5W-1:0] p5_rd;
  logic [P7W-1:0] p7_rd;
  logic wr_lo, wr_hi, access;

  // Port 9 pins
  pafm_port #(.WIDTH(P9W)) u_p9 (
    .latch(p9_data_reg[P9W-1:0]),
    .dir(p9_dir_reg[P9W-1:0]),
    .mode(p9_mode_reg[P9W-1:0]),
    .fsel(p9_fsel_reg[P9W-1:0]),
    .fext(p9_fext_reg[P9W-1:0]),
    .pin_in(p9_pin_in),
    .alt_f1_out(p9_alt_f1),
    .alt_f2_out(p9_alt_f2),
    .alt_f3_out(p9_alt_f3),
    .alt_oe(p9_alt_oe),
    .pin_out(p9_pin_out),
    .pin_oe(p9_pin_oe),
    .alt_in(p9_alt_in),
    .read_val(p9_rd)
  );

  // Port 5 pins, same mux and ordering hazard as port 9
  pafm_port #(.WIDTH(P5W)) u_p5 (
    .latch(p5_data_reg[P5W-1:0]),
    .dir(p5_dir_reg[P5W-1:0]),
    .mode(p5_mode_reg[P5W-1:0]),
    .fsel(p5_fsel_reg[P5W-1:0]),
    .fext(p5_fext_reg[P5W-1:0]),
    .pin_in(p5_pin_in),
    .alt_f1_out(p5_alt_f1),
    .alt_f2_out(p5_alt_f2),
    .alt_f3_out(p5_alt_f3),
    .alt_oe(p5_alt_oe),
    .pin_out(p5_pin_out),
    .pin_oe(p5_pin_oe),
    .alt_in(p5_alt_in),
    .read_val(p5_rd)
  );

  // Port 7: analog path only valid when pin is an input
  assign p7_pin_out = p7_data_reg[P7W-1:0];
  assign p7_pin_oe = ~p7_dir_reg[P7W-1:0];
  assign analog_input_n = p7_dir_reg[P7W-1:0]; // RULE_13
  assign p7_rd = (p7_dir_reg[P7W-1:0] & p7_pin_in) |
                 (~p7_dir_reg[P7W-1:0] & p7_data_reg[P7W-1:0]);
  assign p9_pullup_en = p9_pull_reg[P9W-1:0];

  // Debug pin ownership, set by reset, released by software
  assign debug_reset_input = dbg_reg[PAFM_DBG_RST_BIT] &
                             port0_pin5_in; // RULE_06
  assign port0_pin5_gpio_in = ~dbg_reg[PAFM_DBG_RST_BIT] & port0_pin5_in;
  assign debug_pins_sel = dbg_reg[PAFM_DBG_PINS_BIT]; // RULE_11
  // Flash mode pin bypasses every port register
  assign flash_prog_mode = flash_prog_mode_pin1_in; // RULE_14

  assign wb_dat_o = rdat_reg;
  assign wb_ack_o = ack_reg;
  assign access = wb_req.cyc & wb_req.stb & ~ack_reg;
  // Low byte lane writes low half; high lane, or alias lane 0, writes high
  assign wr_lo = access & wb_req.we & wb_req.sel[0];
  assign wr_hi = access & wb_req.we & wb_req.sel[1];

  // Merge a write into a 16-bit register through direct or alias view
  function automatic logic [15:0] merge16(
    input logic [15:0] cur,
    input logic [7:0] adr,
    input logic [7:0] full_adr,
    input logic [7:0] high_adr,
    input logic lo,
    input logic hi,
    input logic [31:0] d
  );
    logic [15:0] r;
    r = cur;
    if (adr == full_adr)
    begin
      if (lo)
        r = (r & PAFM_HIGH_MASK) | (d[15:0] & PAFM_LOW_MASK);
      if (hi)
        r = (r & PAFM_LOW_MASK) | (d[15:0] & PAFM_HIGH_MASK);
    end
    else if (adr == high_adr && lo)
      r = {d[7:0], r[7:0]}; // RULE_03 RULE_17
    return r;
  endfunction

  // Register next values and read mux
  always_comb
  begin
    p9_data_next = merge16(p9_data_reg, wb_req.adr, PAFM_P9_DATA,
                           PAFM_P9_DATA_H, wr_lo, wr_hi, wb_req.dat);
    p9_dir_next = merge16(p9_dir_reg, wb_req.adr, PAFM_P9_DIR,
                          PAFM_P9_DIR_H, wr_lo, wr_hi, wb_req.dat);
    p9_mode_next = merge16(p9_mode_reg, wb_req.adr, PAFM_P9_MODE,
                           PAFM_P9_MODE_H, wr_lo, wr_hi, wb_req.dat);
    p9_fsel_next = merge16(p9_fsel_reg, wb_req.adr, PAFM_P9_FSEL,
                           PAFM_P9_FSEL_H, wr_lo, wr_hi, wb_req.dat);
    p9_fext_next = merge16(p9_fext_reg, wb_req.adr, PAFM_P9_FEXT,
                           PAFM_P9_FEXT_H, wr_lo, wr_hi, wb_req.dat);
    p9_pull_next = merge16(p9_pull_reg, wb_req.adr, PAFM_P9_PULL,
                           PAFM_P9_PULL_H, wr_lo, wr_hi, wb_req.dat);
    // Port 5 and 7 have no alias; their own address as alias never
    // reaches the alias branch, so other registers' writes cannot leak in
    p5_data_next = merge16(p5_data_reg, wb_req.adr, PAFM_P5_DATA,
                           PAFM_P5_DATA, wr_lo, wr_hi, wb_req.dat);
    p5_dir_next = merge16(p5_dir_reg, wb_req.adr, PAFM_P5_DIR,
                          PAFM_P5_DIR, wr_lo, wr_hi, wb_req.dat);
    p5_mode_next = merge16(p5_mode_reg, wb_req.adr, PAFM_P5_MODE,
                           PAFM_P5_MODE, wr_lo, wr_hi, wb_req.dat);
    p5_fsel_next = merge16(p5_fsel_reg, wb_req.adr, PAFM_P5_FSEL,
                           PAFM_P5_FSEL, wr_lo, wr_hi, wb_req.dat);
    p5_fext_next = merge16(p5_fext_reg, wb_req.adr, PAFM_P5_FEXT,
                           PAFM_P5_FEXT, wr_lo, wr_hi, wb_req.dat);
    p7_data_next = merge16(p7_data_reg, wb_req.adr, PAFM_P7_DATA,
                           PAFM_P7_DATA, wr_lo, wr_hi, wb_req.dat);
    p7_dir_next = merge16(p7_dir_reg, wb_req.adr, PAFM_P7_DIR,
                          PAFM_P7_DIR, wr_lo, wr_hi, wb_req.dat);
    dbg_next = dbg_reg;
    if (wr_lo && wb_req.adr == PAFM_DBG_CTRL)
      dbg_next = wb_req.dat[1:0];
    ack_next = access;
    rdat_next = 32'h00000000;
    if (access && !wb_req.we)
    begin
      unique case (wb_req.adr)
        PAFM_P9_DATA: rdat_next[P9W-1:0] = p9_rd; // RULE_15
        PAFM_P9_DATA_H: rdat_next[7:0] = p9_rd[15:8];
        PAFM_P9_DIR: rdat_next[15:0] = p9_dir_reg;
        PAFM_P9_DIR_H: rdat_next[7:0] = p9_dir_reg[15:8];
        PAFM_P9_MODE: rdat_next[15:0] = p9_mode_reg;
        PAFM_P9_MODE_H: rdat_next[7:0] = p9_mode_reg[15:8]; // RULE_03
        PAFM_P9_FSEL: rdat_next[15:0] = p9_fsel_reg;
        PAFM_P9_FSEL_H: rdat_next[7:0] = p9_fsel_reg[15:8];
        PAFM_P9_FEXT: rdat_next[15:0] = p9_fext_reg;
        PAFM_P9_FEXT_H: rdat_next[7:0] = p9_fext_reg[15:8];
        PAFM_P9_PULL: rdat_next[15:0] = p9_pull_reg;
        PAFM_P9_PULL_H: rdat_next[7:0] = p9_pull_reg[15:8];
        PAFM_P5_DATA: rdat_next[P5W-1:0] = p5_rd;
        PAFM_P5_DIR: rdat_next[P5W-1:0] = p5_dir_reg[P5W-1:0];
        PAFM_P5_MODE: rdat_next[P5W-1:0] = p5_mode_reg[P5W-1:0];
        PAFM_P5_FSEL: rdat_next[P5W-1:0] = p5_fsel_reg[P5W-1:0];
        PAFM_P5_FEXT: rdat_next[P5W-1:0] = p5_fext_reg[P5W-1:0];
        PAFM_P7_DATA: rdat_next[P7W-1:0] = p7_rd;
        PAFM_P7_DIR: rdat_next[15:0] = p7_dir_reg;
        PAFM_DBG_CTRL: rdat_next[1:0] = dbg_reg;
        default: rdat_next = 32'h00000000;
      endcase
    end
  end

  // Registers; reset hands debug pins to the debug unit
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      p9_data_reg <= PAFM_RST_ZERO;
      p9_dir_reg <= PAFM_RST_DIR;
      p9_mode_reg <= PAFM_RST_ZERO;
      p9_fsel_reg <= PAFM_RST_ZERO;
      p9_fext_reg <= PAFM_RST_ZERO;
      p9_pull_reg <= PAFM_RST_ZERO;
      p5_data_reg <= PAFM_RST_ZERO;
      p5_dir_reg <= PAFM_RST_DIR;
      p5_mode_reg <= PAFM_RST_ZERO;
      p5_fsel_reg <= PAFM_RST_ZERO;
      p5_fext_reg <= PAFM_RST_ZERO;
      p7_data_reg <= PAFM_RST_ZERO;
      p7_dir_reg <= PAFM_RST_DIR;
      dbg_reg <= PAFM_RST_DBG; // RULE_06 RULE_11
      ack_reg <= 1'b0;
      rdat_reg <= 32'h00000000;
    end
    else
    begin
      p9_data_reg <= p9_data_next;
      p9_dir_reg <= p9_dir_next;
      p9_mode_reg <= p9_mode_next;
      p9_fsel_reg <= p9_fsel_next;
      p9_fext_reg <= p9_fext_next;
      p9_pull_reg <= p9_pull_next;
      p5_data_reg <= p5_data_next;
      p5_dir_reg <= p5_dir_next;
      p5_mode_reg <= p5_mode_next;
      p5_fsel_reg <= p5_fsel_next;
      p5_fext_reg <= p5_fext_next;
      p7_data_reg <= p7_data_next;
      p7_dir_reg <= p7_dir_next;
      dbg_reg <= dbg_next;
      ack_reg <= ack_next;
      rdat_reg <= rdat_next;
    end
  end

  // Checks
  chk_alias_low_kept : assert property ( // RULE_17
    @(posedge clock) disable iff (sys_rst)
    (access && wb_req.we && wb_req.adr == PAFM_P9_MODE_H)
    |=> p9_mode_reg[7:0] == $past(p9_mode_reg[7:0]))
    else $error("alias write changed low byte");
  chk_alias_high_set : assert property ( // RULE_03
    @(posedge clock) disable iff (sys_rst)
    (access && wb_req.we && wb_req.sel[0] && wb_req.adr == PAFM_P9_FEXT_H)
    |=> p9_fext_reg[15:8] == $past(wb_req.dat[7:0]))
    else $error("alias write missed high byte");
  chk_alt_in_gate : assert property ( // RULE_16
    @(posedge clock) disable iff (sys_rst)
    (p9_alt_in & ~p9_mode_reg[P9W-1:0]) == '0)
    else $error("alternate input not gated");
  chk_data_read : assert property ( // RULE_15
    @(posedge clock) disable iff (sys_rst)
    (access && !wb_req.we && wb_req.adr == PAFM_P9_DATA)
    |=> rdat_reg[P9W-1:0] == $past(p9_rd) && wb_ack_o)
    else $error("data read wrong");
  chk_dbg_reset : assert property ( // RULE_06 RULE_11
    @(posedge clock)
    $past(sys_rst) |-> dbg_reg == PAFM_RST_DBG)
    else $error("debug pins not owned after reset");
  chk_flash_pass : assert property ( // RULE_14
    @(posedge clock) disable iff (sys_rst)
    flash_prog_mode == flash_prog_mode_pin1_in)
    else $error("flash mode pin altered");
  chk_ack_once : assert property (
    @(posedge clock) disable iff (sys_rst)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  chk_ack_follows : assert property (
    @(posedge clock) disable iff (sys_rst)
    access |=> wb_ack_o)
    else $error("request not answered next cycle");
  chk_undef_low : assert property ( // RULE_12
    @(posedge clock) disable iff (sys_rst)
    (p5_pin_out & p5_mode_reg[P5W-1:0] & ~p5_fsel_reg[P5W-1:0] &
     ~p5_fext_reg[P5W-1:0]) == '0)
    else $error("undefined select not parked low");
  chk_undef_p9_low : assert property ( // RULE_01
    @(posedge clock) disable iff (sys_rst)
    (p9_pin_out & p9_mode_reg[P9W-1:0] & ~p9_fsel_reg[P9W-1:0] &
     ~p9_fext_reg[P9W-1:0]) == '0)
    else $error("undefined select not parked low");
endmodule // port_alt_function_mux
